// >>> inc/mcp_pkg.sv
// package for the motor control fault shutdown and conversion timer block
package mcp_pkg;
  // ********************************************************
  // register word indices; byte address is four times the index
  // ********************************************************
  localparam logic [15:0] IDX_SOFT_SHUTDOWN = 16'h2061;
  localparam logic [15:0] IDX_STATUS = 16'h2062;
  localparam logic [15:0] IDX_CONFIG = 16'h2063;
  localparam logic [15:0] IDX_SYNC_WIDTH = 16'h2064;
  localparam logic [15:0] IDX_TRIM = 16'h2065;
  localparam logic [15:0] IDX_PERIOD = 16'h2066;
  localparam logic [15:0] IDX_DUTY_A = 16'h2067;
  localparam logic [15:0] IDX_DUTY_B = 16'h2068;
  localparam logic [15:0] IDX_DUTY_C = 16'h2069;
  localparam logic [15:0] IDX_RESULT_1 = 16'h206A;
  localparam logic [15:0] IDX_RESULT_2 = 16'h206B;
  localparam logic [15:0] IDX_RESULT_3 = 16'h206C;
  localparam logic [15:0] IDX_RESULT_MUX = 16'h206D;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'h206E;
  localparam logic [15:0] IDX_IRQ_MASK = 16'h206F;
  // ********************************************************
  // field positions and reset values
  // ********************************************************
  localparam int CFG_AUX_LSB = 0;
  localparam int CFG_AUX_MSB = 1;
  localparam int CFG_RATE_SEL = 7;
  localparam int IRQ_TRIP = 0;
  localparam int IRQ_SYNC = 1;
  localparam int IRQ_CONV = 2;
  localparam logic [15:0] RST_SYNC_WIDTH = 16'h0064;
  localparam logic [15:0] RST_PERIOD = 16'h1000;
  localparam logic [11:0] CONV_MAX = 12'hFFF;
  localparam logic [11:0] CONV_NONE = 12'h000;
  // ********************************************************
  // sync width limits and clock
  // ********************************************************
  localparam int CLK_MHZ = 250;
  localparam real SYNC_MIN_US = 0.05;
  localparam real SYNC_MAX_US = 12.5;
  localparam int SYNC_MIN_CYC = 13;  // ceil(0.05 us * 250 MHz)
  localparam int SYNC_MAX_CYC = 3125;  // floor(12.5 us * 250 MHz)
  // ********************************************************
  // carriers
  // ********************************************************
  typedef struct packed {
    logic ah;
    logic al;
    logic bh;
    logic bl;
    logic ch;
    logic cl;
  } mcp_gate_t;
  typedef struct packed {
    logic phase_1;
    logic phase_2;
    logic phase_3;
    logic muxed;
  } mcp_cmp_t;
  typedef struct packed {
    logic aux_input_0;
    logic aux_input_1;
    logic aux_input_2;
    logic calib_ref;
  } mcp_aux_t;
endpackage : mcp_pkg

// >>> logic/mcp_core.sv
// fault shutdown of the three-phase gate outputs and single-slope conversion timer
// Notes on behaviour
// - trip pin low shuts down asynchronously
// - shutdown forces gates off, kills sync, interrupts
// - status bit 0 shows live trip pin
// - current sense below threshold trips internally
// - soft shutdown register write trips identically
// - soft shutdown read shows cause, then clears
// - fault clears when pin and sense recover
// - rewrite period, duties; duties latch at sync rise
// - four channels converted simultaneously
// - config bits 1:0 pick aux or reference
// - twelve bit timer measures crossing time
// - sync discharges ramp, timer restarts after
// - sync width register sets pulse width
// - ramp current trim has eight steps
// - config bit 7 picks half or full rate
// - each capture latches timer on trip
// - count saturates at 4095
// - no trip within cycle returns zero
`timescale 1ns/1ps
module mcp_core #(
  parameter int PERIOD_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fault_trip_n,
  input wire logic sense_below_n,
  input wire mcp_pkg::mcp_cmp_t cmp_trip,
  output mcp_pkg::mcp_gate_t gate_on,
  output mcp_pkg::mcp_aux_t aux_sel,
  output logic cycle_sync_pulse,
  output logic ramp_discharge,
  output logic [2:0] ramp_current_source,
  output logic irq
);
  // ********************************************************
  // input synchronisers
  // ********************************************************
  logic pin_s1_r, pin_s2_r, sen_s1_r, sen_s2_r;
  mcp_pkg::mcp_cmp_t cmp_s1_r, cmp_s2_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      sen_s1_r <= 1'b0;
      sen_s2_r <= 1'b0;
      cmp_s1_r <= '0;
      cmp_s2_r <= '0;
    end else begin
      pin_s1_r <= fault_trip_n;
      pin_s2_r <= pin_s1_r;
      sen_s1_r <= sense_below_n;
      sen_s2_r <= sen_s1_r;
      cmp_s1_r <= cmp_trip;
      cmp_s2_r <= cmp_s1_r;
    end
  end
  // ********************************************************
  // apb decode
  // ********************************************************
  logic acc, wr, rd;
  logic [15:0] idx;
  logic mapped;
  assign acc = psel && penable;
  assign wr = acc && pwrite && mapped;
  assign rd = acc && !pwrite && mapped;
  assign idx = paddr[17:2];
  assign pready = 1'b1;
  assign mapped = paddr[1:0] == 2'h0 && idx >= mcp_pkg::IDX_SOFT_SHUTDOWN
    && idx <= mcp_pkg::IDX_IRQ_MASK;
  assign pslverr = acc && !mapped;
  // ********************************************************
  // shutdown latch
  // ********************************************************
  // internal trip line: pin low or sense below threshold
  logic trip_line_n;
  assign trip_line_n = fault_trip_n && sense_below_n;
  logic soft_req_r, soft_cause_r, hw_latch_r, run_ok_r;
  // pin/sense path bypasses pclk so a dead clock still trips
  always_ff @(negedge trip_line_n or negedge presetn) begin
    if (!presetn) begin
      hw_latch_r <= 1'b0;
    end else begin
      hw_latch_r <= ~hw_latch_r;
    end
  end
  logic hw_tog_s1_r, hw_tog_s2_r, hw_tog_s3_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hw_tog_s1_r <= 1'b0;
      hw_tog_s2_r <= 1'b0;
      hw_tog_s3_r <= 1'b0;
    end else begin
      hw_tog_s1_r <= hw_latch_r;
      hw_tog_s2_r <= hw_tog_s1_r;
      hw_tog_s3_r <= hw_tog_s2_r;
    end
  end
  logic hw_event, sw_event, fault_clear;
  assign hw_event = hw_tog_s2_r != hw_tog_s3_r;
  assign sw_event = wr && idx == mcp_pkg::IDX_SOFT_SHUTDOWN && pwdata[0];
  assign fault_clear = pin_s2_r && sen_s2_r;
  // run_ok_r drops on any trip; re-armed once fault cleared and timing rewritten
  logic [3:0] rewrite_r;
  logic rewrite_done;
  assign rewrite_done = &rewrite_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_ok_r <= 1'b0;
    end else begin
      if (hw_event || sw_event) begin
        run_ok_r <= 1'b0;
      end else if (!run_ok_r && fault_clear && rewrite_done) begin
        run_ok_r <= 1'b1;
      end
    end
  end
  // soft shutdown register: cause flag, cleared by read, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_cause_r <= 1'b0;
    end else if (sw_event) begin
      soft_cause_r <= 1'b1;
    end else if (rd && idx == mcp_pkg::IDX_SOFT_SHUTDOWN) begin
      soft_cause_r <= 1'b0;
    end
  end
  assign soft_req_r = soft_cause_r;
  // gate kill is combinational on the raw trip line as well
  logic shutdown;
  assign shutdown = !run_ok_r || !trip_line_n;
  // ********************************************************
  // timing registers and rewrite tracking
  // ********************************************************
  logic [PERIOD_W-1:0] period_r, duty_a_r, duty_b_r, duty_c_r;
  logic [PERIOD_W-1:0] act_a_r, act_b_r, act_c_r;
  logic [15:0] sync_width_r;
  logic [7:0] config_r;
  logic [2:0] trim_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_r <= PERIOD_W'(mcp_pkg::RST_PERIOD);
      duty_a_r <= '0;
      duty_b_r <= '0;
      duty_c_r <= '0;
      sync_width_r <= mcp_pkg::RST_SYNC_WIDTH;
      config_r <= 8'h00;
      trim_r <= 3'h0;
    end else if (wr) begin
      case (idx)
        mcp_pkg::IDX_PERIOD: period_r <= pwdata[PERIOD_W-1:0];
        mcp_pkg::IDX_DUTY_A: duty_a_r <= pwdata[PERIOD_W-1:0];
        mcp_pkg::IDX_DUTY_B: duty_b_r <= pwdata[PERIOD_W-1:0];
        mcp_pkg::IDX_DUTY_C: duty_c_r <= pwdata[PERIOD_W-1:0];
        mcp_pkg::IDX_SYNC_WIDTH: sync_width_r <= pwdata[15:0];
        mcp_pkg::IDX_CONFIG: config_r <= pwdata[7:0];
        mcp_pkg::IDX_TRIM: trim_r <= pwdata[2:0];
        default: ;
      endcase
    end
  end
  // rewrite marks clear on every trip; all four needed before restart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rewrite_r <= 4'hF;
    end else if (hw_event || sw_event) begin
      rewrite_r <= 4'h0;
    end else if (wr && fault_clear) begin
      if (idx == mcp_pkg::IDX_PERIOD) rewrite_r[0] <= 1'b1;
      if (idx == mcp_pkg::IDX_DUTY_A) rewrite_r[1] <= 1'b1;
      if (idx == mcp_pkg::IDX_DUTY_B) rewrite_r[2] <= 1'b1;
      if (idx == mcp_pkg::IDX_DUTY_C) rewrite_r[3] <= 1'b1;
    end
  end
  assign ramp_current_source = trim_r;
  // ********************************************************
  // phase timer and sync pulse
  // ********************************************************
  logic [PERIOD_W-1:0] ph_cnt_r;
  logic [15:0] sync_cnt_r;
  logic sync_r, sync_q_r;
  logic [15:0] sync_len;
  // clamp width into supported range
  assign sync_len = sync_width_r < 16'(mcp_pkg::SYNC_MIN_CYC) ? 16'(mcp_pkg::SYNC_MIN_CYC)
    : sync_width_r > 16'(mcp_pkg::SYNC_MAX_CYC) ? 16'(mcp_pkg::SYNC_MAX_CYC)
    : sync_width_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_cnt_r <= '0;
      sync_cnt_r <= 16'h0000;
      sync_r <= 1'b0;
    end else if (shutdown) begin
      ph_cnt_r <= '0;
      sync_cnt_r <= 16'h0000;
      sync_r <= 1'b0;
    end else if (ph_cnt_r >= period_r - PERIOD_W'(1)) begin
      ph_cnt_r <= '0;
      sync_cnt_r <= sync_len;
      sync_r <= 1'b1;
    end else begin
      ph_cnt_r <= ph_cnt_r + PERIOD_W'(1);
      if (sync_cnt_r > 16'h0001) begin
        sync_cnt_r <= sync_cnt_r - 16'h0001;
      end else begin
        sync_cnt_r <= 16'h0000;
        sync_r <= 1'b0;
      end
    end
  end
  logic sync_rise, sync_fall;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sync_q_r <= 1'b0;
    else sync_q_r <= sync_r;
  end
  assign sync_rise = sync_r && !sync_q_r;
  assign sync_fall = !sync_r && sync_q_r;
  assign cycle_sync_pulse = sync_r && !shutdown;
  assign ramp_discharge = sync_r;
  // duty latched at sync rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_a_r <= '0;
      act_b_r <= '0;
      act_c_r <= '0;
    end else if (sync_rise) begin
      act_a_r <= duty_a_r;
      act_b_r <= duty_b_r;
      act_c_r <= duty_c_r;
    end
  end
  // simple edge-aligned compare; dead time handled elsewhere
  always_comb begin
    gate_on.ah = !shutdown && ph_cnt_r < act_a_r;
    gate_on.al = !shutdown && ph_cnt_r >= act_a_r;
    gate_on.bh = !shutdown && ph_cnt_r < act_b_r;
    gate_on.bl = !shutdown && ph_cnt_r >= act_b_r;
    gate_on.ch = !shutdown && ph_cnt_r < act_c_r;
    gate_on.cl = !shutdown && ph_cnt_r >= act_c_r;
  end
  // ********************************************************
  // conversion timer and captures
  // ********************************************************
  logic [11:0] conv_cnt_r;
  logic half_r, conv_run_r;
  logic [11:0] res_r [4];
  logic [3:0] got_r;
  logic [3:0] cmp_vec;
  assign cmp_vec = cmp_s2_r;
  always_comb begin
    aux_sel = '0;
    case (config_r[mcp_pkg::CFG_AUX_MSB:mcp_pkg::CFG_AUX_LSB])
      2'h0: aux_sel.aux_input_0 = 1'b1;
      2'h1: aux_sel.aux_input_1 = 1'b1;
      2'h2: aux_sel.aux_input_2 = 1'b1;
      default: aux_sel.calib_ref = 1'b1;
    endcase
  end
  logic tick;
  assign tick = config_r[mcp_pkg::CFG_RATE_SEL] || half_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_cnt_r <= 12'h000;
      half_r <= 1'b0;
      conv_run_r <= 1'b0;
    end else if (sync_r) begin
      conv_cnt_r <= 12'h000;
      half_r <= 1'b0;
      conv_run_r <= 1'b0;
    end else if (sync_fall) begin
      conv_run_r <= 1'b1;
    end else if (conv_run_r) begin
      half_r <= !half_r;
      if (tick && conv_cnt_r != mcp_pkg::CONV_MAX) conv_cnt_r <= conv_cnt_r + 12'h001;
    end
  end
  // pending captures; channels not tripped end at zero
  for (genvar i = 0; i < 4; i++) begin : g_cap
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        res_r[i] <= 12'h000;
        got_r[i] <= 1'b0;
      end else if (sync_rise) begin
        if (!got_r[i]) res_r[i] <= mcp_pkg::CONV_NONE;
        got_r[i] <= 1'b0;
      end else if (conv_run_r && cmp_vec[3-i] && !got_r[i]) begin
        res_r[i] <= conv_cnt_r;
        got_r[i] <= 1'b1;
      end
    end
  end
  // ********************************************************
  // interrupts
  // ********************************************************
  logic [2:0] irq_st_r, irq_mask_r, irq_set;
  assign irq_set = {conv_run_r && (&got_r) && !shutdown, sync_rise && !shutdown,
    hw_event || sw_event};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_r <= 3'h0;
      irq_mask_r <= 3'h0;
    end else begin
      if (wr && idx == mcp_pkg::IDX_IRQ_MASK) irq_mask_r <= pwdata[2:0];
      if (wr && idx == mcp_pkg::IDX_IRQ_STATUS) irq_st_r <= (irq_st_r & ~pwdata[2:0]) | irq_set;
      else irq_st_r <= irq_st_r | irq_set;
    end
  end
  assign irq = |(irq_st_r & irq_mask_r);
  // ********************************************************
  // read mux
  // ********************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite && paddr[1:0] == 2'h0) begin
        case (paddr[17:2])
          mcp_pkg::IDX_SOFT_SHUTDOWN: prdata <= {31'h0, soft_req_r};
          mcp_pkg::IDX_STATUS: prdata <= {29'h0, !run_ok_r, sen_s2_r, pin_s2_r};
          mcp_pkg::IDX_CONFIG: prdata <= {24'h0, config_r};
          mcp_pkg::IDX_SYNC_WIDTH: prdata <= {16'h0, sync_width_r};
          mcp_pkg::IDX_TRIM: prdata <= {29'h0, trim_r};
          mcp_pkg::IDX_PERIOD: prdata <= 32'(period_r);
          mcp_pkg::IDX_DUTY_A: prdata <= 32'(duty_a_r);
          mcp_pkg::IDX_DUTY_B: prdata <= 32'(duty_b_r);
          mcp_pkg::IDX_DUTY_C: prdata <= 32'(duty_c_r);
          mcp_pkg::IDX_RESULT_1: prdata <= {20'h0, res_r[0]};
          mcp_pkg::IDX_RESULT_2: prdata <= {20'h0, res_r[1]};
          mcp_pkg::IDX_RESULT_3: prdata <= {20'h0, res_r[2]};
          mcp_pkg::IDX_RESULT_MUX: prdata <= {20'h0, res_r[3]};
          mcp_pkg::IDX_IRQ_STATUS: prdata <= {29'h0, irq_st_r};
          mcp_pkg::IDX_IRQ_MASK: prdata <= {29'h0, irq_mask_r};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
  // ********************************************************
  // checks
  // ********************************************************
  AST_HW_TRIP: assert property (@(posedge pclk) disable iff (!presetn)
    hw_event |=> !run_ok_r && irq_st_r[0] && gate_on == '0) else $error("hw trip");
  AST_SYNC_KILL: assert property (@(posedge pclk) disable iff (!presetn)
    shutdown |=> !sync_r) else $error("sync during shutdown");
  AST_SW_TRIP: assert property (@(posedge pclk) disable iff (!presetn)
    sw_event |=> !run_ok_r && soft_cause_r && irq_st_r[0]) else $error("soft trip");
  AST_RD_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    rd && idx == mcp_pkg::IDX_SOFT_SHUTDOWN && !sw_event |=> !soft_cause_r)
    else $error("read clear");
  AST_NO_RESTART: assert property (@(posedge pclk) disable iff (!presetn)
    !run_ok_r && !fault_clear |=> !run_ok_r) else $error("restart in fault");
  AST_SAT: assert property (@(posedge pclk) disable iff (!presetn)
    conv_cnt_r == mcp_pkg::CONV_MAX && !sync_r |=> conv_cnt_r == mcp_pkg::CONV_MAX)
    else $error("no saturation");
  AST_RESTART: assert property (@(posedge pclk) disable iff (!presetn)
    sync_r |=> conv_cnt_r == 12'h000) else $error("timer not cleared");
  AST_RATE: assert property (@(posedge pclk) disable iff (!presetn)
    conv_run_r && !sync_r && !config_r[mcp_pkg::CFG_RATE_SEL] && !half_r |=> $stable(conv_cnt_r))
    else $error("half rate");
endmodule : mcp_core

// >>> testbench/mcp_core_tb_top.sv
// self-checking bench for the fault shutdown and conversion timer block
`timescale 1ns/1ps
module mcp_core_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, rv;
  logic fault_trip_n, sense_below_n, cycle_sync_pulse, ramp_discharge, irq;
  logic [2:0] ramp_current_source;
  mcp_pkg::mcp_cmp_t cmp_trip;
  mcp_pkg::mcp_gate_t gate_on;
  mcp_pkg::mcp_aux_t aux_sel;
  logic pin_low, sense_low, er;
  logic [63:0] thr;
  int n_mismatch = 0;
  int total_checks = 0;
  int w, sp;
  mcp_core uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .fault_trip_n, .sense_below_n, .cmp_trip, .gate_on, .aux_sel,
    .cycle_sync_pulse, .ramp_discharge, .ramp_current_source, .irq);
  mcp_far_model far (.pclk, .ramp_discharge, .pin_low, .sense_low, .thr,
    .fault_trip_n, .sense_below_n, .cmp_trip);
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // ********************************************************
  // shared tasks
  // ********************************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {14'h0000, idx, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input string nm, input logic [15:0] idx, input logic [31:0] m,
      input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(nm, rv & m, exp);
  endtask : rdc
  task automatic lvl(input logic v);
    int i;
    i = 0;
    while (cycle_sync_pulse !== v && i < 40000) begin
      @(posedge pclk);
      i++;
    end
    chk("sync level", {31'h0, cycle_sync_pulse}, {31'h0, v});
  endtask : lvl
  // ends at a sync rise; w is pulse width, sp is low time after it
  task automatic cyc();
    lvl(1'b0);
    lvl(1'b1);
    w = 0;
    sp = 0;
    while (cycle_sync_pulse === 1'b1 && w < 5000) begin
      @(posedge pclk);
      w++;
    end
    while (cycle_sync_pulse === 1'b0 && sp < 40000) begin
      @(posedge pclk);
      sp++;
    end
  endtask : cyc
  task automatic quiet(input int n);
    int bad;
    bad = 0;
    repeat (n) begin
      @(posedge pclk);
      if (gate_on !== 6'h00 || cycle_sync_pulse !== 1'b0) bad++;
    end
    chk("held off", bad, 32'h0);
  endtask : quiet
  task automatic near(input logic [15:0] idx, input int exp);
    int d;
    apb(1'b0, idx, 32'h0);
    d = int'(rv[11:0]) - exp;
    chk("result distance", (d < -4 || d > 4) ? 32'h1 : 32'h0, 32'h0);
  endtask : near
  task automatic restart();
    apb(1'b1, mcp_pkg::IDX_PERIOD, {16'h0, mcp_pkg::RST_PERIOD});
    apb(1'b1, mcp_pkg::IDX_DUTY_A, 32'h400);
    apb(1'b1, mcp_pkg::IDX_DUTY_B, 32'h400);
    apb(1'b1, mcp_pkg::IDX_DUTY_C, 32'h400);
  endtask : restart
  // ********************************************************
  // scenarios
  // ********************************************************
  task automatic t_reset();
    rdc("period", mcp_pkg::IDX_PERIOD, 32'hFFFF, {16'h0, mcp_pkg::RST_PERIOD});
    rdc("width", mcp_pkg::IDX_SYNC_WIDTH, 32'hFFFF, {16'h0, mcp_pkg::RST_SYNC_WIDTH});
    rdc("trim", mcp_pkg::IDX_TRIM, 32'h7, 32'h0);
    rdc("pin high", mcp_pkg::IDX_STATUS, 32'h1, 32'h1);
    apb(1'b0, 16'h2070, 32'h0);
    chk("unmapped err", {31'h0, er}, 32'h1);
    chk("unmapped data", rv, 32'h0);
  endtask : t_reset
  task automatic t_soft();
    apb(1'b1, mcp_pkg::IDX_IRQ_STATUS, 32'h7);
    apb(1'b1, mcp_pkg::IDX_SOFT_SHUTDOWN, 32'h1);
    repeat (3) @(posedge pclk);
    chk("gates", {26'h0, gate_on}, 32'h0);
    rdc("trip irq", mcp_pkg::IDX_IRQ_STATUS, 32'h1, 32'h1);
    rdc("soft cause", mcp_pkg::IDX_SOFT_SHUTDOWN, 32'h1, 32'h1);
    rdc("soft clear", mcp_pkg::IDX_SOFT_SHUTDOWN, 32'h1, 32'h0);
    quiet(300);
    restart();
    lvl(1'b1);
    repeat (2) @(posedge pclk);
    chk("gates run", {26'h0, gate_on}, 32'h2A);
  endtask : t_soft
  task automatic t_pin();
    logic a;
    apb(1'b1, mcp_pkg::IDX_IRQ_STATUS, 32'h7);
    @(posedge pclk);
    pin_low <= 1'b1;
    #1;
    chk("gates at once", {26'h0, gate_on}, 32'h0);
    repeat (5) @(posedge pclk);
    rdc("pin low", mcp_pkg::IDX_STATUS, 32'h1, 32'h0);
    rdc("trip irq", mcp_pkg::IDX_IRQ_STATUS, 32'h1, 32'h1);
    apb(1'b1, mcp_pkg::IDX_IRQ_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    a = irq;
    apb(1'b1, mcp_pkg::IDX_IRQ_MASK, 32'h7);
    repeat (2) @(posedge pclk);
    chk("mask", {31'h0, a ^ irq}, 32'h1);
    apb(1'b1, mcp_pkg::IDX_IRQ_STATUS, 32'h1);
    rdc("irq clear", mcp_pkg::IDX_IRQ_STATUS, 32'h1, 32'h0);
    quiet(300);
    pin_low <= 1'b0;
    repeat (5) @(posedge pclk);
    sense_low <= 1'b1;
    repeat (5) @(posedge pclk);
    rdc("sense irq", mcp_pkg::IDX_IRQ_STATUS, 32'h1, 32'h1);
    rdc("pin back", mcp_pkg::IDX_STATUS, 32'h1, 32'h1);
    restart();
    quiet(6000);
    sense_low <= 1'b0;
    restart();
    lvl(1'b1);
    rdc("hw cause", mcp_pkg::IDX_SOFT_SHUTDOWN, 32'h1, 32'h0);
  endtask : t_pin
  task automatic t_conv();
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, mcp_pkg::IDX_TRIM, 32'(i));
      @(posedge pclk);
      chk("trim out", {29'h0, ramp_current_source}, 32'(i));
    end
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, mcp_pkg::IDX_CONFIG, 32'h80 | 32'(i));
      @(posedge pclk);
      chk("aux sel", {28'h0, aux_sel}, 32'h8 >> i);
    end
    thr <= {16'd200, 16'd300, 16'hFFFF, 16'd500};
    apb(1'b1, mcp_pkg::IDX_SYNC_WIDTH, 32'h14);
    cyc();
    cyc();
    chk("discharge", {31'h0, ramp_discharge}, 32'h1);
    chk("width", w, 32'h14);
    near(mcp_pkg::IDX_RESULT_1, 200);
    near(mcp_pkg::IDX_RESULT_2, 300);
    near(mcp_pkg::IDX_RESULT_MUX, 500);
    rdc("no trip", mcp_pkg::IDX_RESULT_3, 32'hFFF, 32'h0);
    apb(1'b1, mcp_pkg::IDX_CONFIG, 32'h0);
    apb(1'b1, mcp_pkg::IDX_SYNC_WIDTH, 32'h5);
    cyc();
    cyc();
    chk("width min", w, mcp_pkg::SYNC_MIN_CYC);
    near(mcp_pkg::IDX_RESULT_1, 100);
    thr <= {16'd5000, 48'hFFFF_FFFF_FFFF};
    apb(1'b1, mcp_pkg::IDX_CONFIG, 32'h80);
    apb(1'b1, mcp_pkg::IDX_PERIOD, 32'h2000);
    cyc();
    cyc();
    apb(1'b0, mcp_pkg::IDX_RESULT_1, 32'h0);
    chk("saturate", rv & 32'hFFF, 32'hFFF);
    chk("sync period", w + sp, 32'h2000);
  endtask : t_conv
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results
  // long waits only; a hang past this span is a failure
  initial begin
    repeat (90000) @(posedge pclk);
    n_mismatch++;
    results();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pin_low = 1'b0;
    sense_low = 1'b0;
    thr = 64'hFFFF_FFFF_FFFF_FFFF;
    repeat (16) @(posedge pclk);
    chk("reset gates", {26'h0, gate_on}, 32'h0);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_reset();
    t_soft();
    t_pin();
    t_conv();
    results();
  end
endmodule : mcp_core_tb_top

// >>> testbench/mcp_far_model.sv
// far side model: trip pin, current sense and ramp comparators
`timescale 1ns/1ps
module mcp_far_model (
  input wire logic pclk,
  input wire logic ramp_discharge,
  input wire logic pin_low,
  input wire logic sense_low,
  input wire logic [63:0] thr,
  output logic fault_trip_n,
  output logic sense_below_n,
  output mcp_pkg::mcp_cmp_t cmp_trip
);
  logic [15:0] ramp_r = 16'h0000;
  // ********************************************************
  // ramp in cycles since discharge ended
  // ********************************************************
  always_ff @(posedge pclk) begin
    if (ramp_discharge) begin
      ramp_r <= 16'h0000;
    end else if (ramp_r != 16'hFFFF) begin
      ramp_r <= ramp_r + 16'h0001;
    end
  end
  // pin is driven high by default, so only a held request pulls it low
  assign fault_trip_n = !pin_low;
  assign sense_below_n = !sense_low;
  // threshold of all ones never trips within a cycle
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      cmp_trip[i] = !ramp_discharge && (ramp_r >= thr[16*i +: 16]);
    end
  end
endmodule : mcp_far_model
